/* File: rtl/tcw_ctrl_word_pen.sv */
/*
   Control word receiver and pen alert logic of a serial touch digitizer.
   Assumes the host drives serial clock and data, that serial clock idles
   between frames, and an external pull-up on the pen alert wire.
*/
`timescale 1ns/1ns
module tcw_ctrl_word_pen (
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic SERIAL_CLOCK_I,
   input wire logic SERIAL_DATA_I,
   input wire logic TOUCH_SENSE_I,
   output logic TOUCH_ALERT_N_O,
   output logic TOUCH_ALERT_N_OE_O,
   output logic [2:0] CHAN_SEL_O,
   output logic CONV_8BIT_O,
   output logic REF_SELECT_O,
   output logic REF_DIFF_O,
   output logic [1:0] POWER_CTRL_O,
   output logic REF_POWER_O,
   output logic ADC_POWER_O,
   output logic BAT_DIVIDER_O,
   output logic CONV_BUSY_O,
   output logic PEN_ENABLED_O
);
   import tcw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // decoding helpers, each used in one place

   function automatic logic [4:0] next_ok_cyc(input logic mode8);
      next_ok_cyc = (mode8 == RES_8) ? CYC_NEXT_OK_8 : CYC_NEXT_OK_12;
   endfunction

   function automatic logic [4:0] conv_end_cyc(input logic mode8);
      conv_end_cyc = (mode8 == RES_8) ? CYC_CONV_END_8 : CYC_CONV_END_12;
   endfunction

   function automatic logic pen_allowed(input logic [1:0] pwr);
      pen_allowed = (pwr != PWR_ALWAYS_ON);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // link domain, rising serial clock edge

   tcw_link_state_t link_state;
   tcw_link_state_t next_link_state;
   logic [4:0] cyc;
   logic [4:0] next_cyc;
   logic [5:0] shift;
   logic [5:0] next_shift;
   logic [2:0] link_chan;
   logic [2:0] next_link_chan;
   tcw_word_t link_word;
   tcw_word_t next_link_word;
   logic start_tgl;
   logic next_start_tgl;
   logic word_tgl;
   logic next_word_tgl;
   logic done_tgl;
   logic next_done_tgl;
   logic bat_sample;
   logic next_bat_sample;

   always_comb begin
      next_link_state = link_state;
      next_cyc = cyc;
      next_shift = shift;
      next_link_chan = link_chan;
      next_link_word = link_word;
      next_start_tgl = start_tgl;
      next_word_tgl = word_tgl;
      next_done_tgl = done_tgl;
      case (link_state)
         LK_IDLE: begin
            // zeros before the start bit are dropped
            if (SERIAL_DATA_I) begin
               next_link_state = LK_WORD;
               next_cyc = CYC_START;
               next_start_tgl = ~start_tgl;
            end
         end
         LK_WORD: begin
            next_cyc = cyc + 5'h01;
            next_shift = {shift[4:0], SERIAL_DATA_I};
            if (next_cyc == CYC_CHAN_LAST) begin
               next_link_chan = {shift[1:0], SERIAL_DATA_I};
            end
            if (next_cyc == CYC_WORD_END) begin
               // bit 7 start, then channel, mode, reference, power
               next_link_word = {1'b1, shift, SERIAL_DATA_I};
               next_word_tgl = ~word_tgl;
               next_link_state = LK_CONV;
            end
         end
         LK_CONV: begin
            next_cyc = cyc + 5'h01;
            if (SERIAL_DATA_I && (cyc >= next_ok_cyc(link_word.mode8))) begin
               // overlapped word: conversion end never reported
               next_link_state = LK_WORD;
               next_cyc = CYC_START;
               next_start_tgl = ~start_tgl;
            end else if (next_cyc == conv_end_cyc(link_word.mode8)) begin
               next_done_tgl = ~done_tgl;
               next_link_state = LK_IDLE;
            end
         end
         default: begin
            next_link_state = LK_IDLE;
         end
      endcase
   end

   always_ff @(posedge SERIAL_CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         link_state <= LK_IDLE;
         cyc <= '0;
         shift <= '0;
         link_chan <= CHAN_RESET;
         link_word <= WORD_RESET;
         start_tgl <= 1'b0;
         word_tgl <= 1'b0;
         done_tgl <= 1'b0;
      end else begin
         link_state <= next_link_state;
         cyc <= next_cyc;
         shift <= next_shift;
         link_chan <= next_link_chan;
         link_word <= next_link_word;
         start_tgl <= next_start_tgl;
         word_tgl <= next_word_tgl;
         done_tgl <= next_done_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain, battery divider window

   // the window closes with the last word bit, so the divider never loads
   // the battery input during the conversion itself
   always_comb begin
      // divider on only over the acquisition cycles of a battery word
      next_bat_sample = (next_link_state == LK_WORD)
         && (next_cyc >= CYC_SAMPLE_FIRST)
         && (next_link_chan == CHAN_BATTERY);
   end

   always_ff @(posedge SERIAL_CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         bat_sample <= 1'b0;
      end else begin
         bat_sample <= next_bat_sample;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // link domain, falling serial clock edge

   logic fall4_tgl;
   logic next_fall4_tgl;

   always_comb begin
      next_fall4_tgl = fall4_tgl;
      // fourth falling edge after the start bit
      if ((link_state == LK_WORD) && (cyc == CYC_FALL_RELEASE)) begin
         next_fall4_tgl = ~fall4_tgl;
      end
   end

   always_ff @(negedge SERIAL_CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         fall4_tgl <= 1'b0;
      end else begin
         fall4_tgl <= next_fall4_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // crossing into the system domain

   tcw_cross_t cross_in;
   tcw_cross_t cross_sync;
   tcw_cross_t cross_prev;
   tcw_cross_t next_cross_prev;

   always_comb begin
      cross_in.touch = TOUCH_SENSE_I;
      cross_in.bat_sample = bat_sample;
      cross_in.done_tgl = done_tgl;
      cross_in.fall4_tgl = fall4_tgl;
      cross_in.word_tgl = word_tgl;
      cross_in.start_tgl = start_tgl;
   end

   tcw_sync2 #(
      .WIDTH(SYNC_W)
   ) u_sync (
      .CLOCK_I(CLOCK_I),
      .RESET_I(RESET_I),
      .async_i(cross_in),
      .init_i('0),
      .sync_o(cross_sync)
   );

   logic ev_start;
   logic ev_word;
   logic ev_fall4;
   logic ev_done;

   always_comb begin
      next_cross_prev = cross_sync;
      ev_start = cross_sync.start_tgl ^ cross_prev.start_tgl;
      ev_word = cross_sync.word_tgl ^ cross_prev.word_tgl;
      ev_fall4 = cross_sync.fall4_tgl ^ cross_prev.fall4_tgl;
      ev_done = cross_sync.done_tgl ^ cross_prev.done_tgl;
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         cross_prev <= '0;
      end else begin
         cross_prev <= next_cross_prev;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system domain: control word, pen function, pin drive

   tcw_word_t word;
   tcw_word_t next_word;
   logic pen_en;
   logic next_pen_en;
   logic pend;
   logic next_pend;
   logic hold;
   logic next_hold;
   logic busy;
   logic next_busy;
   logic alert_n;
   logic next_alert_n;
   logic alert_oe;
   logic next_alert_oe;
   logic bat_div;
   logic next_bat_div;
   logic adc_on;
   logic next_adc_on;
   logic pull;

   always_comb begin
      next_word = word;
      next_pen_en = pen_en;
      next_pend = pend;
      next_hold = hold;
      next_busy = busy;
      if (ev_word) begin
         // link word is stable for many link cycles after its toggle
         next_word = link_word;
         // conversion starts at once, no warm-up delay
         next_busy = 1'b1;
         // power bits decide a later re-enable, not the release
         next_pend = pen_allowed({link_word.power_ctrl_hi,
            link_word.power_ctrl_lo});
      end
      if (ev_done) begin
         next_busy = 1'b0;
         if (pend) begin
            next_pen_en = 1'b1;
            next_pend = 1'b0;
         end
      end
      if (ev_fall4) begin
         next_hold = 1'b0;
      end
      if (ev_start) begin
         // start wins over every other event of the same cycle
         next_pen_en = 1'b0;
         next_pend = 1'b0;
         next_busy = 1'b0;
         next_hold = ~alert_n;
      end
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         word <= WORD_RESET;
         pen_en <= 1'b1;
         pend <= 1'b0;
         hold <= 1'b0;
         busy <= 1'b0;
      end else begin
         word <= next_word;
         pen_en <= next_pen_en;
         pend <= next_pend;
         hold <= next_hold;
         busy <= next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // system domain, pin drive and power outputs

   // level and enable share one term, so the pin is never driven high
   always_comb begin
      // pen function works in every power-down state
      pull = (pen_en && cross_sync.touch) || hold;
      next_alert_n = ~pull;
      next_alert_oe = pull;
      next_bat_div = cross_sync.bat_sample;
      next_adc_on = next_busy || word.power_ctrl_lo;
   end

   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         alert_n <= 1'b1;
         alert_oe <= 1'b0;
         bat_div <= 1'b0;
         adc_on <= 1'b0;
      end else begin
         alert_n <= next_alert_n;
         alert_oe <= next_alert_oe;
         bat_div <= next_bat_div;
         adc_on <= next_adc_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all taken from flip-flops, REF_DIFF_O through an inverter

   always_comb begin
      TOUCH_ALERT_N_O = alert_n;
      TOUCH_ALERT_N_OE_O = alert_oe;
      CHAN_SEL_O = {word.chan_sel_hi, word.chan_sel_mid, word.chan_sel_lo};
      CONV_8BIT_O = word.mode8;
      REF_SELECT_O = word.ref_select;
      // differential: reference from the driver switches
      REF_DIFF_O = ~word.ref_select;
      POWER_CTRL_O = {word.power_ctrl_hi, word.power_ctrl_lo};
      REF_POWER_O = word.power_ctrl_hi;
      ADC_POWER_O = adc_on;
      BAT_DIVIDER_O = bat_div;
      CONV_BUSY_O = busy;
      PEN_ENABLED_O = pen_en;
   end
endmodule

/* File: rtl/tcw_pkg.sv */
/*
   Constants, field layout, states and carriers for the touch control word
   and pen alert block. Assumes a serial clock from the host and a 100 MHz
   system clock.
*/
// What this block does
// - bits on the serial input are ignored until a high start bit
// - three channel bits select multiplexer, drivers and reference inputs
// - resolution bit 0 gives 12-bit conversion, 1 gives 8-bit
// - reference bit 1 selects single-ended, 0 selects differential reference
// - differential takes reference from drivers, single-ended from ref pin
// - battery input divided by four, divider on only while sampling
// - enabled pen function pulls open-drain alert low on touch, else idle high
// - alert keeps responding during power-down between conversions
// - first coordinate conversion after power-up is valid, no warm-up
// - pen function enabled straight after power-up
// - start bit disables the pen function at once
// - low alert held until fourth falling clock after start, then released
// - alert release does not re-enable the pen function
// - re-enabled pen function responds only after the conversion ends
// - overlapping start bit disables the pen function before conversion end
// - word is start, channel 6..4, resolution 3, reference 2, power 1..0
// - next word may start every 15th cycle (12-bit) or 11th (8-bit)
// - pen function disabled only when both power bits are 1
// - power bits reset to low 0 and high 1
package tcw_pkg;
   localparam int CYC_W = 5;
   localparam logic [4:0] CYC_START = 5'h01;
   localparam logic [4:0] CYC_CHAN_LAST = 5'h04;
   localparam logic [4:0] CYC_FALL_RELEASE = 5'h04;
   localparam logic [4:0] CYC_SAMPLE_FIRST = 5'h05;
   localparam logic [4:0] CYC_WORD_END = 5'h08;
   localparam logic [4:0] CYC_NEXT_OK_12 = 5'h0f;
   localparam logic [4:0] CYC_NEXT_OK_8 = 5'h0b;
   localparam logic [4:0] CYC_CONV_END_12 = 5'h15;
   localparam logic [4:0] CYC_CONV_END_8 = 5'h11;
   localparam logic [2:0] CHAN_BATTERY = 3'h2;
   localparam logic [2:0] CHAN_RESET = 3'h0;
   localparam logic RES_12 = 1'b0;
   localparam logic RES_8 = 1'b1;
   localparam logic REF_SINGLE = 1'b1;
   localparam logic REF_DIFF = 1'b0;
   localparam logic [1:0] PWR_RESET = 2'h2;
   localparam logic [1:0] PWR_ALWAYS_ON = 2'h3;
   localparam int SYNC_W = 6;

   typedef struct packed {
      logic start;
      logic chan_sel_hi;
      logic chan_sel_mid;
      logic chan_sel_lo;
      logic mode8;
      logic ref_select;
      logic power_ctrl_hi;
      logic power_ctrl_lo;
   } tcw_word_t;

   localparam tcw_word_t WORD_RESET = 8'h02;

   typedef enum logic [2:0] {
      LK_IDLE = 3'b001,
      LK_WORD = 3'b010,
      LK_CONV = 3'b100
   } tcw_link_state_t;

   typedef struct packed {
      logic touch;
      logic bat_sample;
      logic done_tgl;
      logic fall4_tgl;
      logic word_tgl;
      logic start_tgl;
   } tcw_cross_t;
endpackage

/* File: rtl/tcw_sync2.sv */
/*
   Two flip-flop level synchroniser, one per bit of a vector.
   Assumes each bit is a level or a toggle that changes slowly.
*/
`timescale 1ns/1ns
module tcw_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic [WIDTH-1:0] async_i,
   input wire logic [WIDTH-1:0] init_i,
   output logic [WIDTH-1:0] sync_o
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge CLOCK_I or posedge RESET_I) begin
      if (RESET_I) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i ^ init_i;
         sync_o <= meta;
      end
   end
endmodule

/* File: verif/tcw_ctrl_word_pen_checker.sv */
/*
   Concurrent checks on the ports of the control word and pen alert block.
   Assumes binding to tcw_ctrl_word_pen and a 100 MHz system clock.
*/
`timescale 1ns/1ns
module tcw_ctrl_word_pen_checker (
   input wire logic CLOCK_I,
   input wire logic RESET_I,
   input wire logic TOUCH_SENSE_I,
   input wire logic TOUCH_ALERT_N_O,
   input wire logic TOUCH_ALERT_N_OE_O,
   input wire logic [2:0] CHAN_SEL_O,
   input wire logic REF_SELECT_O,
   input wire logic REF_DIFF_O,
   input wire logic [1:0] POWER_CTRL_O,
   input wire logic BAT_DIVIDER_O,
   input wire logic CONV_BUSY_O,
   input wire logic PEN_ENABLED_O
);
   import tcw_pkg::*;
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (RESET_I);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_touch_on;
      (PEN_ENABLED_O && TOUCH_SENSE_I) [*5];
   endsequence
   sequence s_touch_off;
      (PEN_ENABLED_O && !TOUCH_SENSE_I) [*5];
   endsequence
   property p_oe;
      TOUCH_ALERT_N_OE_O == !TOUCH_ALERT_N_O;
   endproperty
   property p_alert_low;
      s_touch_on |-> !TOUCH_ALERT_N_O;
   endproperty
   property p_alert_high;
      s_touch_off |-> TOUCH_ALERT_N_O;
   endproperty
   property p_busy_pen;
      CONV_BUSY_O |-> !PEN_ENABLED_O;
   endproperty
   property p_always_on;
      (POWER_CTRL_O == PWR_ALWAYS_ON && !CONV_BUSY_O) |-> !PEN_ENABLED_O;
   endproperty
   property p_rearm;
      $rose(PEN_ENABLED_O) |-> !CONV_BUSY_O && POWER_CTRL_O != PWR_ALWAYS_ON;
   endproperty
   property p_ref_diff;
      REF_DIFF_O == !REF_SELECT_O;
   endproperty
   property p_reset_vals;
      $fell(RESET_I) |-> POWER_CTRL_O == PWR_RESET && PEN_ENABLED_O && TOUCH_ALERT_N_O;
   endproperty
   property p_bat;
      $rose(BAT_DIVIDER_O) |-> ##[1:40] CHAN_SEL_O == CHAN_BATTERY;
   endproperty
   a_oe: assert property (p_oe) else $error("alert enable and level disagree");
   a_alert_low: assert property (p_alert_low) else $error("alert not low on touch");
   a_alert_high: assert property (p_alert_high) else $error("alert low untouched");
   a_busy_pen: assert property (p_busy_pen) else $error("pen on while busy");
   a_always_on: assert property (p_always_on) else $error("pen on in always-on");
   a_rearm: assert property (p_rearm) else $error("pen enabled too early");
   a_ref_diff: assert property (p_ref_diff) else $error("reference outputs clash");
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset state");
   a_bat: assert property (p_bat) else $error("divider on for other channel");
endmodule

bind tcw_ctrl_word_pen tcw_ctrl_word_pen_checker u_chk (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I),
   .TOUCH_SENSE_I(TOUCH_SENSE_I), .TOUCH_ALERT_N_O(TOUCH_ALERT_N_O),
   .TOUCH_ALERT_N_OE_O(TOUCH_ALERT_N_OE_O), .CHAN_SEL_O(CHAN_SEL_O),
   .REF_SELECT_O(REF_SELECT_O), .REF_DIFF_O(REF_DIFF_O), .POWER_CTRL_O(POWER_CTRL_O),
   .BAT_DIVIDER_O(BAT_DIVIDER_O), .CONV_BUSY_O(CONV_BUSY_O), .PEN_ENABLED_O(PEN_ENABLED_O));

/* File: verif/tcw_host_model.sv */
/*
   Host serial port model that shifts control words into the block.
   Assumes the bench calls frame(); the link clock runs only within frames.
*/
`timescale 1ns/1ns
module tcw_host_model (
   output logic sclk_o,
   output logic sdata_o
);
   int nfall;
   initial begin
      sclk_o = 1'b0;
      sdata_o = 1'b0;
      nfall = 0;
   end
   // one 30 ns link cycle, data set up half a period before the rising edge
   task automatic bit_cyc(input logic b);
      sdata_o = b;
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
      nfall++;
   endtask
   // falls are counted from the start bit on
   task automatic frame(input logic [7:0] w, input int lead, input int tail);
      nfall = -lead;
      #7;
      repeat (lead) bit_cyc(1'b0);
      for (int i = 7; i >= 0; i--) bit_cyc(w[i]);
      repeat (tail) bit_cyc(1'b0);
   endtask
endmodule

/* File: verif/tcw_ctrl_word_pen_tb.sv */
/*
   Self-checking bench for the control word and pen alert block.
   Assumes the host model and the checker are compiled before it.
*/
`timescale 1ns/1ns
module tcw_ctrl_word_pen_tb;
   import tcw_pkg::*;
   logic CLOCK_I, RESET_I, TOUCH_SENSE_I;
   logic alert_n, alert_oe, ref_sel, ref_diff, ref_pwr, adc_pwr, bat, busy, pen, mode8;
   logic [2:0] chan;
   logic [1:0] pwr;
   logic [7:0] w;
   logic bat_seen, pen_seen;
   wire sclk, sdata, alert_wire;
   int err_total, compares;
   assign alert_wire = alert_oe ? 1'b0 : 1'b1; // pull-up on the open-drain wire
   tcw_ctrl_word_pen dut (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .SERIAL_CLOCK_I(sclk),
      .SERIAL_DATA_I(sdata), .TOUCH_SENSE_I(TOUCH_SENSE_I), .TOUCH_ALERT_N_O(alert_n),
      .TOUCH_ALERT_N_OE_O(alert_oe), .CHAN_SEL_O(chan), .CONV_8BIT_O(mode8),
      .REF_SELECT_O(ref_sel), .REF_DIFF_O(ref_diff), .POWER_CTRL_O(pwr), .REF_POWER_O(ref_pwr),
      .ADC_POWER_O(adc_pwr), .BAT_DIVIDER_O(bat), .CONV_BUSY_O(busy), .PEN_ENABLED_O(pen));
   tcw_host_model host (.sclk_o(sclk), .sdata_o(sdata));
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out();
      if (err_total == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic clk(input int n);
      repeat (n) @(posedge CLOCK_I);
   endtask
   // n > 0: wait for that many link falls after the start; else for idle
   task automatic wait_for(input int n);
      int k;
      k = 0;
      do begin
         @(posedge CLOCK_I);
         k++;
      end while (((n > 0) ? host.nfall < n : busy !== 1'b0) && k < 500);
      if (k >= 500) begin
         err_total++;
         close_out();
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      CLOCK_I = 1'b0;
      forever #5 CLOCK_I = ~CLOCK_I;
   end
   initial begin
      RESET_I = 1'b1;
      TOUCH_SENSE_I = 1'b0;
      err_total = 0;
      compares = 0;
      clk(5);
      RESET_I <= 1'b0;
      clk(2);
      chk(pwr, PWR_RESET);
      chk(pen, 1'b1);
      chk(alert_wire, 1'b1);
      chk({ref_pwr, adc_pwr, busy}, {PWR_RESET[1], 1'b0, 1'b0});
      TOUCH_SENSE_I <= 1'b1;
      clk(6);
      chk(alert_wire, 1'b0);
      fork
         host.frame(8'hd0, 3, 13);
         begin
            wait_for(3);
            clk(1);
            chk(pen, 1'b0);
            chk(alert_wire, 1'b0);
            wait_for(4);
            clk(8);
            chk(alert_wire, 1'b1);
            chk(pen, 1'b0);
            wait_for(19);
            clk(1);
            chk({pen, busy}, {1'b0, 1'b1});
         end
      join
      chk({chan, mode8, ref_sel, ref_diff}, {3'h5, RES_12, REF_DIFF, 1'b1});
      chk(pwr, 2'h0);
      wait_for(0);
      chk(pen, 1'b1);
      clk(3);
      chk(alert_wire, 1'b0);
      for (int i = 1; i < 4; i++) begin
         w = {1'b1, (i == 2) ? CHAN_BATTERY : 3'h1, RES_8, REF_SINGLE, 2'(i)};
         bat_seen = 1'b0;
         fork
            host.frame(w, 1, 9);
            repeat (40) begin
               @(posedge CLOCK_I);
               if (bat === 1'b1) bat_seen = 1'b1;
            end
         join
         chk(bat_seen, i == 2);
         chk({chan, mode8, ref_sel, pwr}, {w[6:4], RES_8, REF_SINGLE, w[1:0]});
         wait_for(0);
         chk(pen, i != 3);
         chk({ref_pwr, adc_pwr}, {w[1], w[0]});
         clk(3);
         chk(alert_wire, i == 3);
      end
      pen_seen = 1'b0;
      fork
         begin
            host.frame(8'hd0, 0, 7);
            host.frame(8'hd0, 0, 13);
         end
         repeat (75) begin
            @(posedge CLOCK_I);
            if (pen !== 1'b0) pen_seen = 1'b1;
         end
      join
      chk(pen_seen, 1'b0);
      wait_for(0);
      chk(pen, 1'b1);
      TOUCH_SENSE_I <= 1'b0;
      clk(6);
      chk(alert_wire, 1'b1);
      RESET_I <= 1'b1;
      clk(2);
      chk(pwr, PWR_RESET);
      RESET_I <= 1'b0;
      clk(2);
      chk(pen, 1'b1);
      close_out();
   end
endmodule
